// ### rtl/cmjp_framer.sv
// Purpose : Builds the compatibility header (and join prefix) and parses received ones.
// Assumes : Byte streams on the core clock; generic MAC header handled elsewhere.
// Notes   : Registers on a plain strobe port; read data one cycle after the strobe.
//
// What this block does
// - Each sent PDU carries the compatibility header right after the generic header.
// - The compatibility header is exactly six bytes long.
// - The three reserved bits are always sent as zero.
// - No-merge flag is 0 when merging allowed, 1 when forbidden.
// - Urgency level is a two-bit priority from 0 to 3.
// - Control flag is 0 for data, 1 for control packets.
// - Nine-bit field is connection ident for data, control kind for control.
// - Switch ident is source or destination depending on toward-node flag.
// - Local node number is source or destination depending on toward-node flag.
// - Padding flag marks cipher padding; meaningful with first security profile.
// - Length field counts payload bytes.
// - Control kind uses the standard control kind code values.
// - Join message is recognised by control kind value 1.
// - Registration payload of 8 or 40 bytes parses as compatibility join.
// - In a join, switch ident names the switch being joined through.
// - In a join, local node number is the identifier being assigned.
// - Downlink answer sets aggregation flag only if the whole path aggregates.
// - Negative flag is 1 for negative variant, 0 for positive.
// - Roaming flag is 1 when moving switch, 0 for fresh join.
// - Security capability: 0 none, 1 to 3 the matching profile.
// - Robust link flag set by request; response and acknowledgement echo it.
module cmjp_framer
    import cmjp_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [31:0]      reg_rdata_o,
    // Transmit byte stream
    output logic [7:0]       tx_byte_o,
    output logic             tx_valid_o,
    input  wire logic        tx_ready_i,
    // Receive byte stream
    input  wire logic [7:0]  rx_byte_i,
    input  wire logic        rx_valid_i,
    input  wire logic        rx_start_i,
    input  wire logic        toward_node_flag_i,
    // Path capability from the routing tables
    input  wire logic        path_aggregate_ok_i
);

    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        logic [13:0]      txh0;       // pad, kind, control, urgency, no-merge
        logic [30:0]      txh1;       // length, node number, switch ident
        logic [15:0]      txjoin;
        logic [47:0]      txeui;
        logic             downlink;
        logic             echo;
        logic             busy;
        logic             with_join;
        logic [3:0]       tx_idx;
        logic [7:0]       tx_byte;
        logic             tx_valid;
        logic [47:0]      rxh;
        logic [5:0]       rx_cnt;
        logic             rx_active;
        logic             rx_toward;
        logic             hdr_valid;
        logic             join_done;
        logic [39:0][7:0] rx_pay;
        logic [31:0]      rdata;
    } cmjp_state_t;

    cmjp_state_t s_q;
    cmjp_state_t s_d;

    logic [47:0]  tx_hdr;
    logic [15:0]  tx_flags;
    logic [111:0] tx_frame;
    logic         d_no_merge;
    logic [1:0]   d_urgency;
    logic         d_control;
    logic [8:0]   d_kind;
    logic [7:0]   d_switch;
    logic [13:0]  d_node;
    logic         d_pad;
    logic [8:0]   d_len;
    logic         d_join;
    logic         d_long;

    // =====================================================================
    // Helpers
    // =====================================================================
    // Picks the byte at a given index of the outgoing frame, first byte highest
    function automatic logic [7:0] cmjp_pick(input logic [111:0] frame, input logic [3:0] idx);
        logic [111:0] sh;
        sh = frame << (8 * int'(idx));
        return sh[111 -: 8];
    endfunction : cmjp_pick

    // Reads four payload bytes as one big-endian word
    function automatic logic [31:0] cmjp_word(input logic [39:0][7:0] pay, input int first);
        return {pay[first], pay[first + 1], pay[first + 2], pay[first + 3]};
    endfunction : cmjp_word

    // Test for a write strobe to one register
    function automatic logic cmjp_hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
        return wr && (a == ofs);
    endfunction : cmjp_hit

    // =====================================================================
    // Outgoing header and join prefix
    // =====================================================================
    // Reserved bits forced to zero; fields concatenated most significant first
    assign tx_hdr = {RSV_VALUE,
                     s_q.txh0[0],
                     s_q.txh0[2:1],
                     s_q.txh0[3],
                     s_q.txh0[12:4],
                     s_q.txh1[7:0],
                     s_q.txh1[21:8],
                     s_q.txh0[13],
                     s_q.txh1[30:22]};

    // Join flags: aggregation from path on downlink, robust echoed on answers
    always_comb begin
        tx_flags = s_q.txjoin;
        if (s_q.downlink) begin
            tx_flags[FLAG_AGG_BIT] = path_aggregate_ok_i;
        end
        if (s_q.echo) begin
            tx_flags[FLAG_ROBUST_BIT] = s_q.rx_pay[0][FLAG_ROBUST_BIT - 8];
        end
    end

    assign tx_frame = {tx_hdr, tx_flags, s_q.txeui};

    // =====================================================================
    // Incoming header decode
    // =====================================================================
    cmjp_hdr_unpack u_unpack (
        .hdr_i          (s_q.rxh),
        .no_merge_o     (d_no_merge),
        .urgency_o      (d_urgency),
        .control_o      (d_control),
        .kind_o         (d_kind),
        .switch_ident_o (d_switch),
        .node_number_o  (d_node),
        .padding_o      (d_pad),
        .length_o       (d_len),
        .is_join_o      (d_join),
        .is_long_o      (d_long)
    );

    // =====================================================================
    // Next state
    // =====================================================================
    always_comb begin
        logic [5:0] ridx;
        logic [5:0] last;
        logic [3:0] tlast;
        s_d   = s_q;
        ridx  = rx_start_i ? 6'h00 : s_q.rx_cnt;
        last  = 6'(d_len) + 6'h05;
        tlast = s_q.with_join ? 4'(TX_LAST_JOIN) : 4'(TX_LAST_HDR);

        // Register writes
        if (cmjp_hit(reg_wr_i, reg_addr_i, TXHDR0_OFS)) begin
            s_d.txh0 = reg_wdata_i[13:0];
        end
        if (cmjp_hit(reg_wr_i, reg_addr_i, TXHDR1_OFS)) begin
            s_d.txh1 = reg_wdata_i[30:0];
        end
        if (cmjp_hit(reg_wr_i, reg_addr_i, TXJOIN_OFS)) begin
            s_d.txjoin = reg_wdata_i[15:0];
        end
        if (cmjp_hit(reg_wr_i, reg_addr_i, TXEUI_LO_OFS)) begin
            s_d.txeui[31:0] = reg_wdata_i;
        end
        if (cmjp_hit(reg_wr_i, reg_addr_i, TXEUI_HI_OFS)) begin
            s_d.txeui[47:32] = reg_wdata_i[15:0];
        end
        if (cmjp_hit(reg_wr_i, reg_addr_i, CTRL_OFS)) begin
            s_d.downlink = reg_wdata_i[CTRL_DOWN_BIT];
            s_d.echo     = reg_wdata_i[CTRL_ECHO_BIT];
            // Send command ignored while a header or join prefix is still going out
            if (reg_wdata_i[CTRL_SEND_BIT] && !s_q.busy) begin
                s_d.busy      = 1'b1;
                s_d.with_join = reg_wdata_i[CTRL_JOIN_BIT];
                s_d.tx_idx    = 4'h0;
                s_d.tx_valid  = 1'b1;
                s_d.tx_byte   = tx_hdr[47 -: 8];
            end
        end

        // Transmit byte handshake
        if (s_q.tx_valid && tx_ready_i) begin
            if (s_q.tx_idx == tlast) begin
                s_d.tx_valid = 1'b0;
                s_d.busy     = 1'b0;
            end else begin
                s_d.tx_idx  = s_q.tx_idx + 4'h1;
                s_d.tx_byte = cmjp_pick(tx_frame, s_q.tx_idx + 4'h1);
            end
        end

        // Frame start opens a new capture and drops old results
        if (rx_valid_i && rx_start_i) begin
            s_d.rx_active = 1'b1;
            s_d.hdr_valid = 1'b0;
            s_d.join_done = 1'b0;
            s_d.rx_toward = toward_node_flag_i;
        end

        // Software clears status by writing ones
        if (cmjp_hit(reg_wr_i, reg_addr_i, RXSTAT_OFS)) begin
            if (reg_wdata_i[ST_HDR_BIT]) begin
                s_d.hdr_valid = 1'b0;
            end
            if (reg_wdata_i[ST_DONE_BIT]) begin
                s_d.join_done = 1'b0;
            end
        end

        // Receive byte capture; a set in the same cycle beats a clear
        if (rx_valid_i && (rx_start_i || s_q.rx_active)) begin
            if (ridx < 6'(HDR_BYTES)) begin
                s_d.rxh = {s_q.rxh[39:0], rx_byte_i};
                if (ridx == 6'(HDR_BYTES - 1)) begin
                    s_d.hdr_valid = 1'b1;
                end
            end else if (ridx < 6'(HDR_BYTES + PAY_BYTES)) begin
                s_d.rx_pay[ridx - 6'(HDR_BYTES)] = rx_byte_i;
                if (d_join && (ridx == last)) begin
                    s_d.join_done = 1'b1;
                end
            end
            if (ridx == 6'(HDR_BYTES + PAY_BYTES - 1)) begin
                s_d.rx_active = 1'b0;
            end else begin
                s_d.rx_cnt = ridx + 6'h01;
            end
        end

        // Register reads, answered in the next cycle
        s_d.rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                TXHDR0_OFS:   s_d.rdata = {18'h00000, s_q.txh0};
                TXHDR1_OFS:   s_d.rdata = {1'b0, s_q.txh1};
                TXJOIN_OFS:   s_d.rdata = {16'h0000, s_q.txjoin};
                TXEUI_LO_OFS: s_d.rdata = s_q.txeui[31:0];
                TXEUI_HI_OFS: s_d.rdata = {16'h0000, s_q.txeui[47:32]};
                CTRL_OFS:     s_d.rdata = {27'h0000000, s_q.busy, s_q.echo,
                                           s_q.downlink, s_q.with_join, 1'b0};
                RXHDR0_OFS:   s_d.rdata = {15'h0000, d_control ? 3'h0 : s_q.rxh[RSV_MSB -: 3],
                                           d_pad, d_kind, d_control, d_urgency,
                                           d_no_merge};
                RXHDR1_OFS:   s_d.rdata = {1'b0, d_len, d_node, d_switch};
                RXSTAT_OFS:   s_d.rdata = {27'h0000000, s_q.rx_toward, s_q.join_done,
                                           s_q.hdr_valid && d_long,
                                           s_q.hdr_valid && d_join,
                                           s_q.hdr_valid};
                RXJOIN_OFS:   s_d.rdata = {16'h0000, s_q.rx_pay[0], s_q.rx_pay[1]};
                RXEUI_LO_OFS: s_d.rdata = cmjp_word(s_q.rx_pay, EUI_FIRST + 2);
                RXEUI_HI_OFS: s_d.rdata = {16'h0000, s_q.rx_pay[EUI_FIRST],
                                           s_q.rx_pay[EUI_FIRST + 1]};
                RXSKEY_OFS:        s_d.rdata = cmjp_word(s_q.rx_pay, SKEY_FIRST);
                RXSKEY_OFS + 8'h4: s_d.rdata = cmjp_word(s_q.rx_pay, SKEY_FIRST + 4);
                RXSKEY_OFS + 8'h8: s_d.rdata = cmjp_word(s_q.rx_pay, SKEY_FIRST + 8);
                RXSKEY_OFS + 8'hc: s_d.rdata = cmjp_word(s_q.rx_pay, SKEY_FIRST + 12);
                RXAKEY_OFS:        s_d.rdata = cmjp_word(s_q.rx_pay, AKEY_FIRST);
                RXAKEY_OFS + 8'h4: s_d.rdata = cmjp_word(s_q.rx_pay, AKEY_FIRST + 4);
                RXAKEY_OFS + 8'h8: s_d.rdata = cmjp_word(s_q.rx_pay, AKEY_FIRST + 8);
                RXAKEY_OFS + 8'hc: s_d.rdata = cmjp_word(s_q.rx_pay, AKEY_FIRST + 12);
                default:      s_d.rdata = 32'h0000_0000;                   // Unmapped reads zero
            endcase
        end
    end

    // =====================================================================
    // State register
    // =====================================================================
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata_o = s_q.rdata;
    assign tx_byte_o   = s_q.tx_byte;
    assign tx_valid_o  = s_q.tx_valid;

endmodule : cmjp_framer

// ### rtl/cmjp_hdr_unpack.sv
// Purpose : Splits a 48-bit compatibility header into its fields.
// Assumes : Header bits most significant first, as held by the receiver.
// Notes   : Pure combinational; also recognises the join message.
module cmjp_hdr_unpack
    import cmjp_pkg::*;
(
    input  wire logic [47:0] hdr_i,
    output logic             no_merge_o,
    output logic [1:0]       urgency_o,
    output logic             control_o,
    output logic [8:0]       kind_o,
    output logic [7:0]       switch_ident_o,
    output logic [13:0]      node_number_o,
    output logic             padding_o,
    output logic [8:0]       length_o,
    output logic             is_join_o,
    output logic             is_long_o
);

    // =====================================================================
    // Field split
    // =====================================================================
    assign no_merge_o     = hdr_i[NOMERGE_BIT];
    assign urgency_o      = hdr_i[URG_MSB -: 2];
    assign control_o      = hdr_i[CTRL_BIT];
    assign kind_o         = hdr_i[KIND_MSB -: 9];
    assign switch_ident_o = hdr_i[SWID_MSB -: 8];
    assign node_number_o  = hdr_i[NODE_MSB -: 14];
    assign padding_o      = hdr_i[PAD_BIT];
    assign length_o       = hdr_i[LEN_MSB -: 9];

    // Join message: control kind 1 and only the two join lengths
    assign is_join_o = control_o && (kind_o == JOIN_KIND)
                    && ((length_o == JOIN_SHORT_LEN)
                     || (length_o == JOIN_LONG_LEN));
    assign is_long_o = (length_o == JOIN_LONG_LEN);

endmodule : cmjp_hdr_unpack

// ### rtl/cmjp_pkg.sv
// Purpose : Shared constants for the compatibility header framer and join parser.
// Assumes : Register port with byte addresses, one 32-bit word per register.
// Notes   : Header is 48 bits, sent most significant byte first.
package cmjp_pkg;
    // =====================================================================
    // Header geometry
    // =====================================================================
    localparam int        HDR_BYTES      = 6;
    localparam int        HDR_BITS       = 48;
    localparam int        RSV_MSB        = 47;
    localparam int        NOMERGE_BIT    = 44;
    localparam int        URG_MSB        = 43;
    localparam int        CTRL_BIT       = 41;
    localparam int        KIND_MSB       = 40;
    localparam int        SWID_MSB       = 31;
    localparam int        NODE_MSB       = 23;
    localparam int        PAD_BIT        = 9;
    localparam int        LEN_MSB        = 8;
    localparam logic [2:0] RSV_VALUE     = 3'h0;
    localparam logic [8:0] JOIN_KIND     = 9'h001;
    localparam logic [8:0] JOIN_SHORT_LEN = 9'h008;
    localparam logic [8:0] JOIN_LONG_LEN  = 9'h028;

    // =====================================================================
    // Join payload geometry (flags 16 bits, identifier 48 bits, two keys)
    // =====================================================================
    localparam int        PAY_BYTES      = 40;
    localparam int        FLAG_AGG_BIT   = 8;
    localparam int        FLAG_ROBUST_BIT = 11;
    localparam int        EUI_FIRST      = 2;
    localparam int        SKEY_FIRST     = 8;
    localparam int        AKEY_FIRST     = 24;
    localparam int        TX_LAST_HDR    = 5;
    localparam int        TX_LAST_JOIN   = 13;

    // =====================================================================
    // Register offsets
    // =====================================================================
    localparam logic [7:0] TXHDR0_OFS    = 8'h00;
    localparam logic [7:0] TXHDR1_OFS    = 8'h04;
    localparam logic [7:0] TXJOIN_OFS    = 8'h08;
    localparam logic [7:0] TXEUI_LO_OFS  = 8'h0c;
    localparam logic [7:0] TXEUI_HI_OFS  = 8'h10;
    localparam logic [7:0] CTRL_OFS      = 8'h14;
    localparam logic [7:0] RXHDR0_OFS    = 8'h18;
    localparam logic [7:0] RXHDR1_OFS    = 8'h1c;
    localparam logic [7:0] RXSTAT_OFS    = 8'h20;
    localparam logic [7:0] RXJOIN_OFS    = 8'h24;
    localparam logic [7:0] RXEUI_LO_OFS  = 8'h28;
    localparam logic [7:0] RXEUI_HI_OFS  = 8'h2c;
    localparam logic [7:0] RXSKEY_OFS    = 8'h30;
    localparam logic [7:0] RXAKEY_OFS    = 8'h40;

    // Control register bits
    localparam int        CTRL_SEND_BIT  = 0;
    localparam int        CTRL_JOIN_BIT  = 1;
    localparam int        CTRL_DOWN_BIT  = 2;
    localparam int        CTRL_ECHO_BIT  = 3;
    localparam int        CTRL_BUSY_BIT  = 4;

    // Receive status bits
    localparam int        ST_HDR_BIT     = 0;
    localparam int        ST_JOIN_BIT    = 1;
    localparam int        ST_LONG_BIT    = 2;
    localparam int        ST_DONE_BIT    = 3;
    localparam int        ST_TOWARD_BIT  = 4;
endpackage : cmjp_pkg

// ### tb/cmjp_monitor.sv
// Purpose : Port-level checks for the compatibility header framer.
// Assumes : One clock, synchronous active-high reset.
// Notes   : Attached to every framer by the bind at the foot.
module cmjp_monitor
    import cmjp_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [31:0] reg_rdata_o,
    input  wire logic [7:0]  tx_byte_o,
    input  wire logic        tx_valid_o,
    input  wire logic        tx_ready_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // =====================================================================
    // Checks
    // =====================================================================
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    logic [4:0] take_cnt_q;
    sequence s_take;
        tx_valid_o && tx_ready_i;
    endsequence
    sequence s_mode_wr;
        reg_wr_i && reg_addr_i == CTRL_OFS && !reg_wdata_i[CTRL_SEND_BIT];
    endsequence
    // Counts bytes taken in the current outgoing frame
    always_ff @(posedge core_clk_i) begin
        if (reset_i || !tx_valid_o) take_cnt_q <= 5'h00;
        else if (tx_ready_i) take_cnt_q <= take_cnt_q + 5'h01;
    end
    property p_echo;
        logic [1:0] m;
        (s_mode_wr, m = reg_wdata_i[3:2]) ##1 (reg_rd_i && reg_addr_i == CTRL_OFS)
            |=> reg_rdata_o[3:2] == m;
    endproperty
    a_rdata_idle: assert property (reg_rdata_o != 32'h0 |-> $past(reg_rd_i))
        else $error("read data outside read slot");
    a_valid_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
        else $error("tx byte dropped or changed while stalled");
    a_send_start: assert property (reg_wr_i && reg_addr_i == CTRL_OFS && reg_wdata_i[0]
        && !tx_valid_o |=> tx_valid_o) else $error("send did not start frame");
    a_first_rsv: assert property ($rose(tx_valid_o) |-> tx_byte_o[7:5] == RSV_VALUE)
        else $error("reserved bits not zero");
    a_frame_len: assert property (s_take |-> take_cnt_q < 5'd14)
        else $error("frame longer than allowed");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 8'hfc |=> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (reg_rd_i && reg_addr_i == RXHDR1_OFS |=> !reg_rdata_o[31])
        else $error("upper bit of header word set");
    a_ctrl_echo: assert property (p_echo) else $error("mode bits not read back");
endmodule : cmjp_monitor

bind cmjp_framer cmjp_monitor u_mon (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tx_byte_o(tx_byte_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i));

// ### tb/cmjp_peer.sv
// Purpose : Far-side MAC model: stalling byte sink and frame source.
// Assumes : Shares the core clock with the framer.
// Notes   : Idle receive byte shows the inverse of the last one sent.
module cmjp_peer (
    input  wire logic       clk_i,
    input  wire logic       slow_i,
    input  wire logic [7:0] tx_byte_i,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o = 1'b1,
    output logic [7:0]      rx_byte_o = 8'h5a,
    output logic            rx_valid_o = 1'b0,
    output logic            rx_start_o = 1'b0,
    output logic            toward_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got [0:255];
    int         n_got = 0;
    bit         phase = 1'b0;
    // Sink: ready every other cycle when slow, bytes logged when taken
    always @(posedge clk_i) begin
        phase <= !phase;
        tx_ready_o <= !slow_i || phase;
        if (tx_valid_i && tx_ready_o) begin
            got[n_got] <= tx_byte_i;
            n_got <= n_got + 1;
        end
    end
    // Source: header MSB first, then payload bytes 8'h10 upward
    task automatic send(input logic [47:0] hdr, input int plen, input logic toward);
        for (int k = 0; k < 6 + plen; k++) begin
            @(posedge clk_i);
            rx_valid_o <= 1'b1;
            rx_start_o <= (k == 0);
            toward_o <= toward;
            rx_byte_o <= (k < 6) ? hdr[47 - 8 * k -: 8] : 8'(k + 10);
        end
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_start_o <= 1'b0;
        rx_byte_o <= ~rx_byte_o;
        toward_o <= ~toward;
    endtask : send
endmodule : cmjp_peer

// ### tb/tb.sv
// Purpose : Self-checking bench for the compatibility header framer.
// Assumes : 20 MHz core clock, reset held three cycles.
// Notes   : Peer model sinks the transmit stream and drives the receive stream.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cmjp_pkg::*;
    // =====================================================================
    // Harness
    // =====================================================================
    logic        clk = 0, rst = 1, wr = 0, rd = 0, slow = 0, agg_ok = 0;
    logic [7:0]  addr = 8'h00, txb, rxb;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic        txv, txr, rxv, rxs, tow;
    int          n_mismatch = 0, samples_checked = 0;
    always #25 clk = ~clk;
    cmjp_framer u_dut (.core_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .tx_byte_o(txb), .tx_valid_o(txv),
        .tx_ready_i(txr), .rx_byte_i(rxb), .rx_valid_i(rxv), .rx_start_i(rxs),
        .toward_node_flag_i(tow), .path_aggregate_ok_i(agg_ok));
    cmjp_peer u_peer (.clk_i(clk), .slow_i(slow), .tx_byte_i(txb), .tx_valid_i(txv),
        .tx_ready_o(txr), .rx_byte_o(rxb), .rx_valid_o(rxv), .rx_start_o(rxs), .toward_o(tow));
    task automatic chk(input string what, input logic [47:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    // Header from fields; f holds {control, urgency, no-merge}, padding is ~no-merge
    function automatic logic [47:0] mk_hdr(input logic [8:0] kind, len, input logic [7:0] sw,
                                           input logic [13:0] node, input logic [3:0] f);
        return {RSV_VALUE, f[0], f[2:1], f[3], kind, sw, node, ~f[0], len};
    endfunction : mk_hdr
    task automatic load_hdr(input logic [8:0] kind, len, input logic [7:0] sw,
                            input logic [13:0] node, input logic [3:0] f);
        wr_reg(TXHDR0_OFS, {18'h0, ~f[0], kind, f});
        wr_reg(TXHDR1_OFS, {1'b0, len, node, sw});
    endtask : load_hdr
    task automatic tx_frame(input logic [31:0] ctl, input int n, input logic [111:0] exp);
        int base;
        base = u_peer.n_got;
        wr_reg(CTRL_OFS, ctl);
        for (int t = 0; t < 200 && u_peer.n_got < base + n; t++) @(posedge clk);
        repeat (3) @(posedge clk);
        chk("tx byte count", 48'(u_peer.n_got - base), 48'(n));
        for (int k = 0; k < n; k++) chk("tx byte", 48'(u_peer.got[base + k]), 48'(exp[111 - 8 * k -: 8]));
        chk("tx idle", 48'(txv), 48'h0);
    endtask : tx_frame
    // =====================================================================
    // Scenarios
    // =====================================================================
    task automatic t_reset();
        rd_reg(CTRL_OFS);
        chk("ctrl at reset", 48'(d), 48'h0);
        rd_reg(RXSTAT_OFS);
        chk("status at reset", 48'(d), 48'h0);
        rd_reg(8'hfc);
        chk("unmapped read", 48'(d), 48'h0);
    endtask : t_reset
    task automatic t_tx_hdr();
        for (int i = 0; i < 4; i++) begin
            slow <= i[0];
            load_hdr(i[1] ? JOIN_KIND : 9'(9'h1a5 - i), 9'(9'h100 | i), 8'(8'h3c + i),
                     14'(14'h2a5b >> i), {i[1], 2'(i), i[0]});
            tx_frame(32'h1, 6, {mk_hdr(i[1] ? JOIN_KIND : 9'(9'h1a5 - i), 9'(9'h100 | i),
                     8'(8'h3c + i), 14'(14'h2a5b >> i), {i[1], 2'(i), i[0]}), 64'h0});
        end
    endtask : t_tx_hdr
    task automatic t_tx_join(input logic ok);
        agg_ok <= ok;
        slow <= !ok;
        load_hdr(JOIN_KIND, JOIN_SHORT_LEN, 8'h21, 14'h0abc, 4'b1011);
        wr_reg(TXJOIN_OFS, 32'hcda3);
        wr_reg(TXEUI_LO_OFS, 32'h89abcdef);
        wr_reg(TXEUI_HI_OFS, 32'h4567);
        tx_frame({28'h0, !ok, 3'h7}, 14,
                 {mk_hdr(JOIN_KIND, JOIN_SHORT_LEN, 8'h21, 14'h0abc, 4'b1011),
                 4'hc, ok, 2'h2, ok, 8'ha3, 48'h456789abcdef});
    endtask : t_tx_join
    task automatic t_echo();
        @(posedge clk);
        wr <= 1'b1;
        addr <= CTRL_OFS;
        wdata <= 32'ha;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("ctrl mode bits", 48'(rdata[3:1]), 48'h5);
        wr_reg(CTRL_OFS, 32'h0);
    endtask : t_echo
    task automatic t_rx(input logic [8:0] len, input logic tw);
        logic j;
        j = (len == JOIN_SHORT_LEN) || (len == JOIN_LONG_LEN);
        u_peer.send(mk_hdr(JOIN_KIND, len, 8'h21, 14'h0abc, 4'b1011), int'(len), tw);
        repeat (2) @(posedge clk);
        rd_reg(RXSTAT_OFS);
        chk("rx status", 48'(d), 48'({tw, j, len == JOIN_LONG_LEN, j, 1'b1}));
        rd_reg(RXHDR0_OFS);
        chk("rx header word 0", 48'(d), 48'h001b);
        rd_reg(RXHDR1_OFS);
        chk("rx header word 1", 48'(d), 48'({1'b0, len, 14'h0abc, 8'h21}));
        rd_reg(RXJOIN_OFS);
        chk("rx join flags", 48'(d), 48'h1011);
        rd_reg(RXEUI_LO_OFS);
        chk("rx eui low", 48'(d), 48'h14151617);
        rd_reg(RXSKEY_OFS);
        if (len == JOIN_LONG_LEN) chk("rx session key", 48'(d), 48'h18191a1b);
        wr_reg(RXSTAT_OFS, 32'h9);
        rd_reg(RXSTAT_OFS);
        chk("rx status cleared", 48'(d), 48'({tw, 4'h0}));
    endtask : t_rx
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    // Main sequence and watchdog
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_tx_hdr();
        t_tx_join(1'b1);
        t_tx_join(1'b0);
        t_echo();
        t_rx(9'd8, 1'b0);
        t_rx(9'd9, 1'b1);
        t_rx(9'd40, 1'b1);
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
endmodule : tb
